/* smf_pkg.sv */
`default_nettype none

package smf_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 200_000_000; // Clock rate
  localparam int unsigned CLK_PERIOD_NS = 5;           // Clock period
  localparam int unsigned START_LAT_NS  = 1000;        // Typical start latency
  localparam int unsigned START_LAT_CYC = START_LAT_NS / CLK_PERIOD_NS;
  localparam int unsigned LAT_W         = 8;           // Latency counter width
  localparam int unsigned DIV_W         = 10;          // Divider counter width

  // ****************************************
  // Bit rates in bits per second
  // ****************************************
  localparam int unsigned BPS_125K = 125_000;
  localparam int unsigned BPS_250K = 250_000;
  localparam int unsigned BPS_500K = 500_000;
  localparam int unsigned BPS_1M   = 1_000_000;
  localparam int unsigned BPS_2M   = 2_000_000;
  localparam int unsigned BPS_4M   = 4_000_000;
  localparam int unsigned BPS_8M   = 8_000_000;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] OFS_RXD    = 12'h518; // Received byte
  localparam logic [11:0] OFS_TXD    = 12'h51c; // Byte to send
  localparam logic [11:0] OFS_RATE   = 12'h524; // serial_bit_rate
  localparam logic [11:0] OFS_CFG    = 12'h554; // serial_format_config
  localparam logic [11:0] OFS_STATUS = 12'h560; // Engine status

  // ****************************************
  // Rate field encodings, one-hot
  // ****************************************
  localparam logic [31:0] RATE_125K  = 32'h0200_0000;
  localparam logic [31:0] RATE_250K  = 32'h0400_0000;
  localparam logic [31:0] RATE_500K  = 32'h0800_0000;
  localparam logic [31:0] RATE_1M    = 32'h1000_0000;
  localparam logic [31:0] RATE_2M    = 32'h2000_0000;
  localparam logic [31:0] RATE_4M    = 32'h4000_0000;
  localparam logic [31:0] RATE_8M    = 32'h8000_0000;
  localparam logic [31:0] RATE_RESET = 32'h0400_0000;

  // ****************************************
  // Format and status fields
  // ****************************************
  localparam int unsigned CFG_W        = 3;     // Implemented config bits
  localparam logic [2:0]  CFG_RESET    = 3'h0;  // All modes zero
  localparam int unsigned CFG_ORDER    = 0;     // 1: low_bit_leads
  localparam int unsigned CFG_PHASE    = 1;     // clock_phase
  localparam int unsigned CFG_POLARITY = 2;     // 1: pulses_low
  localparam int unsigned ST_BUSY      = 0;     // Byte in flight
  localparam int unsigned ST_FULL      = 1;     // Transmit FIFO full
  localparam int unsigned ST_RX_READY  = 2;     // Unread received byte
  localparam int unsigned BYTE_W       = 8;     // Serial word width
  localparam int unsigned FIFO_DEPTH   = 8;     // Transmit FIFO depth
  localparam logic [3:0]  LAST_EDGE    = 4'hf;  // Sixteenth clock edge

  // Engine states
  typedef enum logic [1:0] {
    SMF_IDLE  = 2'b00,  // Clock parked at idle level
    SMF_WAIT  = 2'b01,  // Start latency running
    SMF_SHIFT = 2'b10   // Byte on the wire
  } smf_state_e;

endpackage

`default_nettype wire

/* smf_fifo.sv */
`default_nettype none

module smf_fifo #(
  parameter int unsigned WIDTH = 8,  // Word width
  parameter int unsigned DEPTH = 8   // Word count
) (
  input  wire logic             i_mclk,     // System clock
  input  wire logic             i_rst_n,    // Async reset, low
  input  wire logic             i_wr_valid, // Word offered
  output logic                  o_wr_ready, // Room for a word
  input  wire logic [WIDTH-1:0] i_wr_data,  // Word in
  output logic                  o_rd_valid, // Word available
  input  wire logic             i_rd_ready, // Consumer takes word
  output logic      [WIDTH-1:0] o_rd_data   // Oldest word
);

  localparam int unsigned AW = $clog2(DEPTH); // Pointer width

  // ****************************************
  // Storage and pointers
  // ****************************************
  logic [WIDTH-1:0] mem_reg [DEPTH];   // Word store
  logic [WIDTH-1:0] mem_next [DEPTH];  // Next store
  logic [AW-1:0]    wr_ptr_reg;        // Write slot
  logic [AW-1:0]    wr_ptr_next;       // Next write slot
  logic [AW-1:0]    rd_ptr_reg;        // Read slot
  logic [AW-1:0]    rd_ptr_next;       // Next read slot
  logic [AW:0]      cnt_reg;           // Words held
  logic [AW:0]      cnt_next;          // Next count
  logic             push;              // Word accepted
  logic             pop;               // Word removed

  // Full and empty straight from the count
  assign o_wr_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign o_rd_valid = (cnt_reg != '0);
  assign o_rd_data  = mem_reg[rd_ptr_reg];
  assign push       = i_wr_valid && o_wr_ready;
  assign pop        = i_rd_ready && o_rd_valid;

  // Next pointers, count and store
  always_comb begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = i_wr_data;
      wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Register only
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_reg    <= '{default: '0};
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      mem_reg    <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg    <= cnt_next;
    end
  end

endmodule

`default_nettype wire

/* smf_spi_master.sv */
// The strobed register port was decided locally.
`default_nettype none

module smf_spi_master #(
  parameter int unsigned FIFO_DEPTH = smf_pkg::FIFO_DEPTH  // Transmit words
) (
  input  wire logic        i_mclk,     // 200 MHz system clock
  input  wire logic        i_rst_n,    // Async reset, low
  input  wire logic [11:0] i_addr,     // Register byte address
  input  wire logic [31:0] i_wdata,    // Write data
  input  wire logic        i_wr,       // Write strobe
  input  wire logic        i_rd,       // Read strobe
  output logic      [31:0] o_rdata,    // Read data, cycle after strobe
  output logic             o_tx_ready, // FIFO can take a byte
  output logic             o_busy,     // Byte in flight
  output logic             o_sck,      // Serial clock out
  output logic             o_mosi,     // Serial data out
  input  wire logic        i_miso      // Serial data in, asynchronous
);

  // ****************************************
  // Half-period counts per rate
  // ****************************************
  // Rounded down so the bit rate never runs slow; a half period is at most a cycle short
  localparam int unsigned HZ = smf_pkg::CLK_HZ;
  localparam int unsigned DW = smf_pkg::DIV_W;
  localparam logic [DW-1:0] HALF_125K = DW'(HZ / (2 * smf_pkg::BPS_125K));
  localparam logic [DW-1:0] HALF_250K = DW'(HZ / (2 * smf_pkg::BPS_250K));
  localparam logic [DW-1:0] HALF_500K = DW'(HZ / (2 * smf_pkg::BPS_500K));
  localparam logic [DW-1:0] HALF_1M   = DW'(HZ / (2 * smf_pkg::BPS_1M));
  localparam logic [DW-1:0] HALF_2M   = DW'(HZ / (2 * smf_pkg::BPS_2M));
  localparam logic [DW-1:0] HALF_4M   = DW'(HZ / (2 * smf_pkg::BPS_4M));
  localparam logic [DW-1:0] HALF_8M   = DW'(HZ / (2 * smf_pkg::BPS_8M));
  localparam int unsigned LW = smf_pkg::LAT_W;
  localparam logic [LW-1:0] LAT_LAST = LW'(smf_pkg::START_LAT_CYC - 1);
  localparam int unsigned BW = smf_pkg::BYTE_W;

  // ****************************************
  // Declarations
  // ****************************************
  // Input synchroniser
  logic [1:0]        miso_sync_reg;   // Two-stage MISO sampler
  logic [1:0]        miso_sync_next;  // Next sampler value
  logic              miso_s;          // Safe MISO level

  // Software registers
  logic [31:0]       rate_reg;        // serial_bit_rate
  logic [31:0]       rate_next;       // Next rate
  logic [2:0]        cfg_reg;         // serial_format_config low bits
  logic [2:0]        cfg_next;        // Next config
  logic [31:0]       rdata_reg;       // Read data register
  logic [31:0]       rdata_next;      // Next read data
  logic [BW-1:0]     rxd_reg;         // Last received byte
  logic [BW-1:0]     rxd_next;        // Next received byte
  logic              rx_rdy_reg;      // Unread byte flag
  logic              rx_rdy_next;     // Next flag

  // Shift engine
  smf_pkg::smf_state_e state_reg;     // Engine state
  smf_pkg::smf_state_e state_next;    // Next state
  logic [LW-1:0]     lat_reg;         // Start latency count
  logic [LW-1:0]     lat_next;        // Next latency count
  logic [DW-1:0]     div_reg;         // Half-period divider
  logic [DW-1:0]     div_next;        // Next divider
  logic [3:0]        edge_reg;        // Clock edge index
  logic [3:0]        edge_next;       // Next edge index
  logic              sck_reg;         // Serial clock level
  logic              sck_next;        // Next clock level
  logic              mosi_reg;        // Serial data level
  logic              mosi_next;       // Next data level
  logic [BW-1:0]     tx_sh_reg;       // Outgoing shifter
  logic [BW-1:0]     tx_sh_next;      // Next outgoing shifter
  logic [BW-1:0]     rx_sh_reg;       // Incoming shifter
  logic [BW-1:0]     rx_sh_next;      // Next incoming shifter

  // Combinational helpers
  logic [DW-1:0]     half_cnt;        // Cycles per half period
  logic              tick;            // One-cycle half-period enable
  logic              leading;         // Tick is a leading edge
  logic              do_sample;       // Capture MISO now
  logic              do_shift;        // Present next bit now
  logic              byte_done;       // Last edge of a byte
  logic              lsb_first;       // Order field
  logic              phase;           // clock_phase field
  logic              polarity;        // clock_polarity field
  logic              wr_txd;          // Software writes a byte
  logic              rd_rxd;          // Software reads the byte

  // FIFO handshake
  logic              fifo_rd_valid;   // Byte waiting
  logic              fifo_rd_ready;   // Engine takes byte
  logic [BW-1:0]     fifo_rd_data;    // Waiting byte

  // ****************************************
  // Field decode
  // ****************************************
  assign lsb_first = cfg_reg[smf_pkg::CFG_ORDER];
  assign phase     = cfg_reg[smf_pkg::CFG_PHASE];
  assign polarity  = cfg_reg[smf_pkg::CFG_POLARITY];
  assign wr_txd    = i_wr && (i_addr == smf_pkg::OFS_TXD);
  assign rd_rxd    = i_rd && (i_addr == smf_pkg::OFS_RXD);

  // ****************************************
  // MISO synchroniser
  // ****************************************
  // Only the second stage feeds any logic
  always_comb begin
    miso_sync_next = {miso_sync_reg[0], i_miso};
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      miso_sync_reg <= 2'h0;
    end else begin
      miso_sync_reg <= miso_sync_next;
    end
  end

  assign miso_s = miso_sync_reg[1];

  // ****************************************
  // Transmit FIFO
  // ****************************************
  // A write while full is dropped; software checks the full bit
  smf_fifo #(
    .WIDTH (BW),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_mclk     (i_mclk),
    .i_rst_n    (i_rst_n),
    .i_wr_valid (wr_txd),
    .o_wr_ready (o_tx_ready),
    .i_wr_data  (i_wdata[BW-1:0]),
    .o_rd_valid (fifo_rd_valid),
    .i_rd_ready (fifo_rd_ready),
    .o_rd_data  (fifo_rd_data)
  );

  // ****************************************
  // Rate selection
  // ****************************************
  // Any encoding outside the seven falls back to 250 kbps
  always_comb begin
    unique case (rate_reg)
      smf_pkg::RATE_125K: half_cnt = HALF_125K;
      smf_pkg::RATE_250K: half_cnt = HALF_250K;
      smf_pkg::RATE_500K: half_cnt = HALF_500K;
      smf_pkg::RATE_1M:   half_cnt = HALF_1M;
      smf_pkg::RATE_2M:   half_cnt = HALF_2M;
      smf_pkg::RATE_4M:   half_cnt = HALF_4M;
      smf_pkg::RATE_8M:   half_cnt = HALF_8M;
      default:            half_cnt = HALF_250K;
    endcase
  end

  // ****************************************
  // Edge timing
  // ****************************************
  // Divider runs from the system clock, so its accuracy is the clock's
  assign tick      = (state_reg == smf_pkg::SMF_SHIFT)
                     && (div_reg == half_cnt - 1'b1);
  assign leading   = ~edge_reg[0];
  assign do_sample = tick && (phase ? ~leading : leading);
  assign do_shift  = tick && (phase ? leading : ~leading);
  assign byte_done = tick && (edge_reg == smf_pkg::LAST_EDGE);

  // ****************************************
  // Shift engine next state
  // ****************************************
  always_comb begin
    state_next    = state_reg;
    lat_next      = lat_reg;
    div_next      = div_reg;
    edge_next     = edge_reg;
    sck_next      = sck_reg;
    mosi_next     = mosi_reg;
    tx_sh_next    = tx_sh_reg;
    rx_sh_next    = rx_sh_reg;
    fifo_rd_ready = 1'b0;
    unique case (state_reg)
      smf_pkg::SMF_IDLE: begin
        // Clock parks at its idle level, data low
        sck_next  = polarity;
        mosi_next = 1'b0;
        lat_next  = '0;
        if (fifo_rd_valid) begin
          state_next = smf_pkg::SMF_WAIT;
        end
      end
      smf_pkg::SMF_WAIT: begin
        // Hold off the typical start latency
        sck_next = polarity;
        lat_next = lat_reg + 1'b1;
        if (lat_reg == LAT_LAST) begin
          fifo_rd_ready = 1'b1;
          div_next      = '0;
          edge_next     = '0;
          state_next    = smf_pkg::SMF_SHIFT;
          if (phase) begin
            // First bit goes out on the first leading edge
            tx_sh_next = fifo_rd_data;
          end else begin
            // First bit must stand before the first leading edge
            mosi_next  = lsb_first ? fifo_rd_data[0] : fifo_rd_data[BW-1];
            tx_sh_next = lsb_first ? (fifo_rd_data >> 1) : (fifo_rd_data << 1);
          end
        end
      end
      smf_pkg::SMF_SHIFT: begin
        div_next = tick ? '0 : div_reg + 1'b1;
        if (tick) begin
          // Sixteen toggles return the clock to idle
          sck_next  = ~sck_reg;
          edge_next = edge_reg + 1'b1;
        end
        if (do_shift) begin
          mosi_next  = lsb_first ? tx_sh_reg[0] : tx_sh_reg[BW-1];
          tx_sh_next = lsb_first ? (tx_sh_reg >> 1) : (tx_sh_reg << 1);
        end
        if (do_sample) begin
          // Received bits pack in the same order as sent
          rx_sh_next = lsb_first ? {miso_s, rx_sh_reg[BW-1:1]}
                                 : {rx_sh_reg[BW-2:0], miso_s};
        end
        if (byte_done) begin
          state_next = smf_pkg::SMF_IDLE;
        end
      end
      default: begin
        // Unused code recovers to idle
        state_next = smf_pkg::SMF_IDLE;
      end
    endcase
  end

  // Shift engine registers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= smf_pkg::SMF_IDLE;
      lat_reg   <= '0;
      div_reg   <= '0;
      edge_reg  <= 4'h0;
      sck_reg   <= 1'b0;
      mosi_reg  <= 1'b0;
      tx_sh_reg <= '0;
      rx_sh_reg <= '0;
    end else begin
      state_reg <= state_next;
      lat_reg   <= lat_next;
      div_reg   <= div_next;
      edge_reg  <= edge_next;
      sck_reg   <= sck_next;
      mosi_reg  <= mosi_next;
      tx_sh_reg <= tx_sh_next;
      rx_sh_reg <= rx_sh_next;
    end
  end

  // ****************************************
  // Register file next state
  // ****************************************
  // Mode changes mid-byte take effect at once; change them while idle
  always_comb begin
    rate_next   = rate_reg;
    cfg_next    = cfg_reg;
    rxd_next    = rxd_reg;
    rx_rdy_next = rx_rdy_reg;
    rdata_next  = 32'h0;
    if (i_wr && (i_addr == smf_pkg::OFS_RATE)) begin
      rate_next = i_wdata;
    end
    if (i_wr && (i_addr == smf_pkg::OFS_CFG)) begin
      cfg_next = i_wdata[smf_pkg::CFG_W-1:0];
    end
    if (rd_rxd) begin
      rx_rdy_next = 1'b0;
    end
    // Completion wins over a read in the same cycle
    if (byte_done) begin
      rxd_next    = rx_sh_next;
      rx_rdy_next = 1'b1;
    end
    if (i_rd) begin
      unique case (i_addr)
        smf_pkg::OFS_RXD: begin
          rdata_next[BW-1:0] = rxd_reg;
        end
        smf_pkg::OFS_RATE: begin
          rdata_next = rate_reg;
        end
        smf_pkg::OFS_CFG: begin
          rdata_next[smf_pkg::CFG_W-1:0] = cfg_reg;
        end
        smf_pkg::OFS_STATUS: begin
          rdata_next[smf_pkg::ST_BUSY]     = o_busy;
          rdata_next[smf_pkg::ST_FULL]     = ~o_tx_ready;
          rdata_next[smf_pkg::ST_RX_READY] = rx_rdy_reg;
        end
        default: begin
          // Unmapped and write-only addresses read zero
          rdata_next = 32'h0;
        end
      endcase
    end
  end

  // Register file registers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rate_reg   <= smf_pkg::RATE_RESET;
      cfg_reg    <= smf_pkg::CFG_RESET;
      rdata_reg  <= 32'h0;
      rxd_reg    <= '0;
      rx_rdy_reg <= 1'b0;
    end else begin
      rate_reg   <= rate_next;
      cfg_reg    <= cfg_next;
      rdata_reg  <= rdata_next;
      rxd_reg    <= rxd_next;
      rx_rdy_reg <= rx_rdy_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Busy covers the latency wait as well as the byte itself
  assign o_busy  = (state_reg != smf_pkg::SMF_IDLE);
  assign o_rdata = rdata_reg;
  assign o_sck   = sck_reg;
  assign o_mosi  = mosi_reg;

endmodule

`default_nettype wire

/* smf_props.sv */
`default_nettype none

// ****************************************
// Port-level checks of the serial master
// ****************************************
module smf_props #(
  parameter int unsigned FIFO_DEPTH = 8  // Transmit words
) (
  input wire logic        i_mclk,     // Clock
  input wire logic        i_rst_n,    // Reset, low
  input wire logic [11:0] i_addr,     // Address
  input wire logic [31:0] i_wdata,    // Write data
  input wire logic        i_wr,       // Write strobe
  input wire logic        i_rd,       // Read strobe
  input wire logic [31:0] o_rdata,    // Read data
  input wire logic        o_tx_ready, // FIFO room
  input wire logic        o_busy,     // Engine busy
  input wire logic        o_sck,      // Serial clock
  input wire logic        o_mosi,     // Serial out
  input wire logic        i_miso      // Serial in
);
  logic [31:0] rate_reg;  // Shadow of rate register
  logic [31:0] rate_next; // Next shadow rate
  logic [2:0]  cfg_reg;   // Shadow of format register
  logic [2:0]  cfg_next;  // Next shadow format

  // Shadows follow software writes only
  always_comb begin
    rate_next = rate_reg;
    cfg_next = cfg_reg;
    if (i_wr && i_addr == smf_pkg::OFS_RATE) begin
      rate_next = i_wdata;
    end
    if (i_wr && i_addr == smf_pkg::OFS_CFG) begin
      cfg_next = i_wdata[2:0];
    end
  end

  // Shadow registers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rate_reg <= smf_pkg::RATE_RESET;
      cfg_reg <= 3'h0;
    end else begin
      rate_reg <= rate_next;
      cfg_reg <= cfg_next;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_rate_read: assert property (i_rd && i_addr == smf_pkg::OFS_RATE |=>
    o_rdata == $past(rate_reg)) else $error("rate read mismatch");
  a_cfg_read: assert property (i_rd && i_addr == smf_pkg::OFS_CFG |=>
    o_rdata == {29'h0, $past(cfg_reg)}) else $error("format read mismatch");
  a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (i_rd && i_addr == 12'h100 |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_idle_sck: assert property (!o_busy && $past(!o_busy) && !$past(i_wr) |->
    o_sck == cfg_reg[2]) else $error("idle clock level wrong");
  a_idle_ready: assert property (!o_busy && $past(!o_busy) && !$past(i_wr) |->
    o_tx_ready) else $error("idle with full buffer");
  a_wait_quiet: assert property ($rose(o_busy) |-> $stable(o_sck)[*8])
    else $error("clock moved during start wait");
  a_half_hold: assert property (o_busy && $changed(o_sck) |=> $stable(o_sck)[*8])
    else $error("clock half period too short");
endmodule

`default_nettype wire

/* smf_spi_slave_model.sv */
`default_nettype none

// ****************************************
// Behavioural slave on the serial bus
// ****************************************
module smf_spi_slave_model (
  input  wire logic       i_sck,  // Serial clock
  input  wire logic       i_mosi, // Data from master
  input  wire logic [2:0] i_mode, // Order, phase, polarity
  input  wire logic       i_load, // Start of a new byte
  input  wire logic [7:0] i_tx,   // Byte to return
  output logic            o_miso, // Data to master
  output logic      [7:0] o_rx    // Byte received
);
  timeunit 1ns;
  timeprecision 100ps;
  int         k;  // Bit index
  logic [7:0] tx; // Held reply

  // Bit k in the chosen order
  function automatic logic pick(input int n);
    return i_mode[0] ? tx[n] : tx[7-n];
  endfunction

  // New byte; phase 0 needs the first bit before any edge
  always @(posedge i_load) begin
    tx = i_tx;
    k = 0;
    o_rx = 8'h0;
    o_miso = i_mode[1] ? ~i_tx[0] : pick(0);
  end

  // Leading edge leaves the idle level, trailing returns to it
  always @(i_sck) begin
    if (i_sck !== i_mode[2]) begin
      if (i_mode[1]) begin
        o_miso = pick(k);
      end else begin
        o_rx = i_mode[0] ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
      end
    end else begin
      if (i_mode[1]) begin
        o_rx = i_mode[0] ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
      end
      k++;
      // Past the eighth bit the line shows junk, not the last bit
      o_miso = (k < 8 && !i_mode[1]) ? pick(k) : ~o_miso;
    end
  end
endmodule

`default_nettype wire

/* tb.sv */
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_mclk, i_rst_n, i_wr, i_rd, o_tx_ready, o_busy, o_sck, o_mosi, i_miso, load;
  logic [11:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [7:0]  sl_tx, sl_rx;
  logic [2:0]  mode;
  int          failures, total_checks, cycles;
  typedef struct {logic [31:0] rate; logic [2:0] cfg; logic [7:0] tx, sb; int half;} smf_row_s;
  // Every rate, and seven of the eight order, phase and polarity settings, all but 3'h5
  smf_row_s rows [7] = '{'{smf_pkg::RATE_125K, 3'h0, 8'ha5, 8'h3c, 800},
    '{smf_pkg::RATE_250K, 3'h1, 8'h81, 8'h7e, 400}, '{smf_pkg::RATE_500K, 3'h2, 8'h01, 8'hc3, 200},
    '{smf_pkg::RATE_1M, 3'h3, 8'hf0, 8'h18, 100}, '{smf_pkg::RATE_2M, 3'h4, 8'h6d, 8'h99, 50},
    '{smf_pkg::RATE_4M, 3'h6, 8'hfe, 8'h01, 25}, '{smf_pkg::RATE_8M, 3'h7, 8'h5a, 8'he7, 12}};

  smf_spi_master smf_spi_master_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_tx_ready(o_tx_ready),
    .o_busy(o_busy), .o_sck(o_sck), .o_mosi(o_mosi), .i_miso(i_miso));
  smf_spi_slave_model smf_spi_slave_model_i (.i_sck(o_sck), .i_mosi(o_mosi), .i_mode(mode),
    .i_load(load), .i_tx(sl_tx), .o_miso(i_miso), .o_rx(sl_rx));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  // Hang guard, far above the longest run
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 70000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic run_row(input smf_row_s r);
    int t, first, second, edges;
    logic [31:0] d;
    logic s;
    wr(smf_pkg::OFS_RATE, r.rate);
    wr(smf_pkg::OFS_CFG, {29'h0, r.cfg});
    mode = r.cfg;
    wr(smf_pkg::OFS_TXD, {24'h0, r.tx});
    sl_tx = r.sb;
    load = 1'b1;
    #1 load = 1'b0;
    s = o_sck;
    t = 0;
    first = 0;
    second = 0;
    edges = 0;
    // Track clock edges until the engine rests
    while (t < 20000 && !(t > 10 && !o_busy)) begin
      @(posedge i_mclk);
      #1 t++;
      if (o_sck !== s) begin
        edges++;
        if (edges == 1) first = t;
        if (edges == 2) second = t;
      end
      s = o_sck;
    end
    chk("edges", 16, edges);
    chk("half", r.half, second - first);
    chk("start", 1, (first - r.half) inside {[195:205]});
    chk("idle sck", r.cfg[2], o_sck);
    chk("slave rx", r.tx, sl_rx);
    rd(smf_pkg::OFS_STATUS, d);
    chk("status", 32'h1 << smf_pkg::ST_RX_READY, d);
    rd(smf_pkg::OFS_RXD, d);
    chk("rxd", r.sb, d);
    rd(smf_pkg::OFS_RATE, d);
    chk("rate", r.rate, d);
    rd(smf_pkg::OFS_CFG, d);
    chk("cfg", r.cfg, d);
    repeat (10) @(posedge i_mclk);
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] d;
    int t, q, n;
    i_rst_n = 1'b0;
    {i_wr, i_rd, load, i_addr, i_wdata, sl_tx, mode} = '0;
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    foreach (rows[i]) run_row(rows[i]);
    // Unmapped place: write lost, read zero
    wr(12'h100, 32'hffff_ffff);
    rd(12'h100, d);
    chk("unmapped", 32'h0, d);
    // Fill past depth, then drain; the ninth byte is dropped
    for (int i = 0; i < 9; i++) begin
      wr(smf_pkg::OFS_TXD, 32'h0000_00c0 + i);
      // Wait past the edge so the new count has settled
      if (i == 7) #1 chk("full", 1'b0, o_tx_ready);
    end
    t = 0;
    // Engine is already busy with the first byte, so count it too
    q = 1;
    n = 0;
    while (t < 8000 && q < 20) begin
      @(posedge i_mclk);
      #1 t++;
      n += (o_busy && q > 0) ? 1 : 0;
      q = o_busy ? 0 : q + 1;
    end
    chk("bytes", 8, n);
    // Second reset in mid-run restores defaults
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(smf_pkg::OFS_RATE, d);
    chk("rate reset", smf_pkg::RATE_RESET, d);
    rd(smf_pkg::OFS_CFG, d);
    chk("cfg reset", 32'h0, d);
    chk("sck reset", 32'h0, o_sck);
    give_verdict();
  end
endmodule

bind smf_spi_master smf_props #(.FIFO_DEPTH(FIFO_DEPTH)) smf_props_i (.i_mclk(i_mclk),
  .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_tx_ready(o_tx_ready), .o_busy(o_busy), .o_sck(o_sck),
  .o_mosi(o_mosi), .i_miso(i_miso));

`default_nettype wire
